// >>> verilog/receive_filter_status_control.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module receive_filter_status_control
  import rx_filter_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon slave
  input wire logic [rx_filter_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // frame start and frame end report from receive path, same clock
  input wire logic frameDone,
  input wire logic frameStart,
  input wire logic tableMatch,
  input wire logic destGroup,
  input wire logic destAllOnes,
  input wire logic fcsBad,
  input wire logic alignBad,
  input wire logic collided,
  input wire logic [15:0] frameBytes,
  input wire logic [15:0] remainingWords,
  input wire logic [15:0] endThresholdWords,
  // carrier sense pin
  input wire logic carrierPin,
  // software reset command
  input wire logic softReset,
  // results
  output logic frameAccept,
  output logic descWrite,
  output logic [15:0] descStatusWord,
  output var rx_filter_pkg::loop_mode_t loopMode,
  output logic xcvrLoopEnable
);
  import rx_filter_pkg::*;

  logic [15:0] rfc;
  logic [15:0] cfg2;
  logic carrierMeta, carrierSync;
  logic readPending;
  logic [31:0] readData;

  // bus decode
  wire hitRfc = (avs_address == RFC_OFFSET);
  wire hitCfg2 = (avs_address == CFG2_OFFSET);
  wire wrLow = avs_write && avs_byteenable[0];
  wire wrHigh = avs_write && avs_byteenable[1];
  wire [15:0] beMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] swMask = beMask & RFC_SW_MASK;

  // frame classification
  wire isShort = (frameBytes < MIN_FRAME_BYTES);
  wire isUnicast = !destGroup;
  wire anyErr = fcsBad || collided;
  wire acceptCond = tableMatch
    || (rfc[B_SHORT] && isShort)
    || (rfc[B_ALLONES] && destAllOnes)
    || (rfc[B_UNICAST] && isUnicast)
    || (rfc[B_GROUP] && destGroup);
  wire errOk = rfc[B_ACCEPT_ERR] || !anyErr;
  wire accepted = frameDone && acceptCond && errOk;
  wire loopActive = (rfc[B_LOOP_HI:B_LOOP_LO] != 2'b00);
  wire goodFrame = !fcsBad && !alignBad && !isShort && !collided;

  // status image of the accepted frame
  wire [8:0] newStatus;
  assign newStatus[B_GROUP_SEEN] = destGroup;
  assign newStatus[B_ALLONES_SEEN] = destAllOnes;
  assign newStatus[B_FINAL] = (remainingWords <= endThresholdWords);
  assign newStatus[B_CARRIER] = carrierSync;
  assign newStatus[B_COLLISION] = collided;
  assign newStatus[B_FCS] = fcsBad && !alignBad;
  assign newStatus[B_MISALIGN] = fcsBad && alignBad;
  assign newStatus[B_LOOP_OK] = loopActive && goodFrame;
  assign newStatus[B_GOOD] = goodFrame;

  // carrier and collision survive frame start
  wire [15:0] clearedRfc = rfc & ~STATUS_CLEAR_MASK;
  wire [15:0] statusRfc = {rfc[15:9], newStatus | (rfc[8:0] & ~STATUS_CLEAR_MASK[8:0])};
  wire [15:0] swRfc = (rfc & ~swMask) | (avs_writedata[15:0] & swMask);
  wire rfcWr = avs_write && hitRfc && (wrLow || wrHigh) && !avs_waitrequest;
  wire [15:0] next_rfc = accepted ? statusRfc
    : frameStart ? clearedRfc
    : rfcWr ? swRfc
    : rfc;
  wire [15:0] cfgMask = beMask;
  wire cfgWr = avs_write && hitCfg2 && !avs_waitrequest;
  wire [15:0] next_cfg2 = cfgWr ? ((cfg2 & ~cfgMask) | (avs_writedata[15:0] & cfgMask)) : cfg2;
  wire [31:0] next_readData = hitRfc ? {16'h0000, rfc}
    : hitCfg2 ? {16'h0000, cfg2}
    : UNMAPPED_READ;

  assign avs_waitrequest = avs_read && !readPending;
  assign avs_readdata = readData;
  assign loopMode = loop_mode_t'(rfc[B_LOOP_HI:B_LOOP_LO]);
  assign xcvrLoopEnable = (loopMode == LOOP_XCVR) && cfg2[B_XCVR_LOOP_EN];

  // carrier synchroniser
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrierMeta <= 1'b0;
      carrierSync <= 1'b0;
    end
    else
    begin
      carrierMeta <= carrierPin;
      carrierSync <= carrierMeta;
    end
  end

  // registers; softReset deliberately unused here
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rfc <= RFC_RESET;
      cfg2 <= CFG2_RESET;
    end
    else
    begin
      rfc <= next_rfc;
      cfg2 <= next_cfg2;
    end
  end

  // read takes one wait cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readPending <= 1'b0;
      readData <= 32'h00000000;
    end
    else
    begin
      readPending <= avs_read && !readPending;
      if (avs_read && !readPending)
        readData <= next_readData;
    end
  end

  // descriptor status output
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameAccept <= 1'b0;
      descWrite <= 1'b0;
      descStatusWord <= 16'h0000;
    end
    else
    begin
      frameAccept <= accepted;
      descWrite <= accepted;
      if (accepted)
        descStatusWord <= statusRfc;
    end
  end

  property p_soft_reset;
    @(posedge core_clk) disable iff (!rst_n)
    softReset && !frameStart && !frameDone && !rfcWr |=> rfc == $past(rfc);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset changed register");

  property p_desc_copy;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> descWrite && descStatusWord == rfc;
  endproperty
  a_desc_copy: assert property (p_desc_copy) else $error("status word differs from register");

  property p_reject_err;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && anyErr && !rfc[B_ACCEPT_ERR] |=> !descWrite;
  endproperty
  a_reject_err: assert property (p_reject_err) else $error("errored frame accepted");

  property p_clear_next;
    @(posedge core_clk) disable iff (!rst_n)
    frameStart && !frameDone |=> (rfc & STATUS_CLEAR_MASK) == 16'h0000;
  endproperty
  a_clear_next: assert property (p_clear_next) else $error("status not cleared");

  property p_misalign;
    @(posedge core_clk) disable iff (!rst_n)
    accepted && alignBad && fcsBad |=> rfc[B_MISALIGN] && !rfc[B_FCS];
  endproperty
  a_misalign: assert property (p_misalign) else $error("alignment bit wrong");

  property p_misalign_alone;
    @(posedge core_clk) disable iff (!rst_n)
    accepted && !fcsBad |=> !rfc[B_MISALIGN];
  endproperty
  a_misalign_alone: assert property (p_misalign_alone) else $error("misalign set without fcs");

  property p_group_accept;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && rfc[B_GROUP] && destGroup && errOk |=> frameAccept && rfc[B_GROUP_SEEN];
  endproperty
  a_group_accept: assert property (p_group_accept) else $error("group frame dropped");

  property p_no_filter;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && rfc[15:11] == 5'b00000 && !tableMatch |=> !frameAccept;
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("unmatched frame accepted");

  property p_good;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> rfc[B_GOOD] == $past(goodFrame);
  endproperty
  a_good: assert property (p_good) else $error("good frame bit wrong");

  property p_read_wait;
    @(posedge core_clk) disable iff (!rst_n)
    avs_read && !readPending |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answer timing");

  property p_table_accept;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && tableMatch && errOk |=> frameAccept;
  endproperty
  a_table_accept: assert property (p_table_accept) else $error("table match frame dropped");

  property p_err_accept;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && rfc[B_ACCEPT_ERR] && tableMatch |=> frameAccept;
  endproperty
  a_err_accept: assert property (p_err_accept) else $error("errored frame not accepted");

  property p_short_accept;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && rfc[B_SHORT] && isShort && errOk |=> frameAccept;
  endproperty
  a_short_accept: assert property (p_short_accept) else $error("short frame dropped");

  property p_allones_accept;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && rfc[B_ALLONES] && destAllOnes && errOk |=> frameAccept;
  endproperty
  a_allones_accept: assert property (p_allones_accept) else $error("all-ones frame dropped");

  property p_unicast_accept;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && rfc[B_UNICAST] && !destGroup && errOk |=> frameAccept;
  endproperty
  a_unicast_accept: assert property (p_unicast_accept) else $error("individual frame dropped");

  property p_group_seen;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> rfc[B_GROUP_SEEN] == $past(destGroup);
  endproperty
  a_group_seen: assert property (p_group_seen) else $error("group seen bit wrong");

  property p_allones_seen;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> rfc[B_ALLONES_SEEN] == $past(destAllOnes);
  endproperty
  a_allones_seen: assert property (p_allones_seen) else $error("all-ones seen bit wrong");

  property p_final;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> rfc[B_FINAL] == ($past(remainingWords) <= $past(endThresholdWords));
  endproperty
  a_final: assert property (p_final) else $error("final frame bit wrong");

  property p_carrier;
    @(posedge core_clk) disable iff (!rst_n)
    accepted && carrierSync |=> rfc[B_CARRIER];
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier bit missing");

  property p_collision;
    @(posedge core_clk) disable iff (!rst_n)
    accepted && collided |=> rfc[B_COLLISION];
  endproperty
  a_collision: assert property (p_collision) else $error("collision bit missing");

  property p_fcs;
    @(posedge core_clk) disable iff (!rst_n)
    accepted && fcsBad && !alignBad |=> rfc[B_FCS] && !rfc[B_MISALIGN];
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs bit wrong");

  property p_loop_ok;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> rfc[B_LOOP_OK] == (loopMode != LOOP_NONE && $past(goodFrame));
  endproperty
  a_loop_ok: assert property (p_loop_ok) else $error("loopback ok bit wrong");

  property p_upper_kept;
    @(posedge core_clk) disable iff (!rst_n)
    accepted |=> rfc[B_ACCEPT_ERR:B_LOOP_LO] == $past(rfc[B_ACCEPT_ERR:B_LOOP_LO]);
  endproperty
  a_upper_kept: assert property (p_upper_kept) else $error("control bits changed by frame");

  property p_sticky_keep;
    @(posedge core_clk) disable iff (!rst_n)
    frameStart && !frameDone |=> rfc[B_CARRIER:B_COLLISION] == $past(rfc[B_CARRIER:B_COLLISION]);
  endproperty
  a_sticky_keep: assert property (p_sticky_keep) else $error("carrier or collision cleared");

  property p_sw_readonly;
    @(posedge core_clk) disable iff (!rst_n)
    rfcWr && !frameStart && !frameDone |=> rfc[B_GROUP_SEEN:B_GOOD] == $past(rfc[B_GROUP_SEEN:B_GOOD]);
  endproperty
  a_sw_readonly: assert property (p_sw_readonly) else $error("status bits written by software");

  property p_sw_write;
    @(posedge core_clk) disable iff (!rst_n)
    rfcWr && wrHigh && !frameStart && !frameDone
      |=> rfc[B_ACCEPT_ERR:B_LOOP_LO] == $past(avs_writedata[B_ACCEPT_ERR:B_LOOP_LO]);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("filter enables not written");

  property p_reject_status;
    @(posedge core_clk) disable iff (!rst_n)
    frameDone && !accepted && !frameStart |=> rfc[B_GROUP_SEEN:B_GOOD] == $past(rfc[B_GROUP_SEEN:B_GOOD]);
  endproperty
  a_reject_status: assert property (p_reject_status) else $error("rejected frame changed status");

  property p_xcvr_gate;
    @(posedge core_clk) disable iff (!rst_n)
    loopMode == LOOP_XCVR && !cfg2[B_XCVR_LOOP_EN] |-> !xcvrLoopEnable;
  endproperty
  a_xcvr_gate: assert property (p_xcvr_gate) else $error("transceiver loop without enable");

  property p_write_nowait;
    @(posedge core_clk) disable iff (!rst_n)
    avs_write |-> !avs_waitrequest;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");

  property p_accept_pair;
    @(posedge core_clk) disable iff (!rst_n)
    descWrite |-> frameAccept;
  endproperty
  a_accept_pair: assert property (p_accept_pair) else $error("descriptor write without accept");

  property p_unmapped;
    @(posedge core_clk) disable iff (!rst_n)
    avs_read && !readPending && !hitRfc && !hitCfg2 |=> avs_readdata == UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : receive_filter_status_control
`default_nettype wire

// >>> verilog/rx_filter_pkg.sv
`default_nettype none
package rx_filter_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] RFC_OFFSET = 4'h2;
  localparam logic [3:0] CFG2_OFFSET = 4'h3;
  localparam int RFC_INDEX = 2;
  localparam int CFG2_INDEX = 3;
  localparam int B_ACCEPT_ERR = 15;
  localparam int B_SHORT = 14;
  localparam int B_ALLONES = 13;
  localparam int B_UNICAST = 12;
  localparam int B_GROUP = 11;
  localparam int B_LOOP_HI = 10;
  localparam int B_LOOP_LO = 9;
  localparam int B_GROUP_SEEN = 8;
  localparam int B_ALLONES_SEEN = 7;
  localparam int B_FINAL = 6;
  localparam int B_CARRIER = 5;
  localparam int B_COLLISION = 4;
  localparam int B_FCS = 3;
  localparam int B_MISALIGN = 2;
  localparam int B_LOOP_OK = 1;
  localparam int B_GOOD = 0;
  localparam int B_XCVR_LOOP_EN = 6;
  localparam logic [15:0] RFC_RESET = 16'h0000;
  localparam logic [15:0] RFC_SW_MASK = 16'hFE00;
  localparam logic [15:0] STATUS_CLEAR_MASK = 16'h01CF;
  localparam logic [15:0] CFG2_RESET = 16'h0000;
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_MAC, LOOP_CODEC, LOOP_XCVR} loop_mode_t;
endpackage : rx_filter_pkg
`default_nettype wire

// >>> verif/rx_net_model.sv
`timescale 1ns/10ps
`default_nettype none
module rx_net_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // frame request
  input wire logic go,
  input wire logic [5:0] q,
  input wire logic [15:0] bytes,
  // frame report
  output logic frameStart,
  output logic frameDone,
  output logic [5:0] flags,
  output logic [15:0] frameBytes
);
  logic [1:0] sh;
  // qualifiers stand only with frameDone, otherwise they toggle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh <= 2'h0;
      frameStart <= 1'b0;
      frameDone <= 1'b0;
      flags <= 6'h00;
      frameBytes <= 16'h0000;
    end
    else
    begin
      sh <= {sh[0], go};
      frameStart <= go;
      frameDone <= sh[1];
      flags <= sh[1] ? q : ~flags;
      frameBytes <= sh[1] ? bytes : ~frameBytes;
    end
  end
endmodule : rx_net_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rx_filter_pkg::*;
  logic core_clk, rst_n, avs_read, avs_write, go, carrierPin, softReset;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic avs_waitrequest, frameStart, frameDone, frameAccept, descWrite, xcvrLoopEnable;
  logic [5:0] q, flags;
  logic [15:0] bytes, frameBytes, remW, thrW, descStatusWord, mreg;
  loop_mode_t loopMode;
  int error_cnt, checks;
  logic [6:0] hs [11] = '{7'h00, 7'h00, 7'h10, 7'h04, 7'h08, 7'h20, 7'h00, 7'h40, 7'h43, 7'h01, 7'h02};
  logic [5:0] qs [11] = '{6'h20, 6'h00, 6'h18, 6'h10, 6'h00, 6'h00, 6'h24, 6'h26, 6'h25, 6'h20, 6'h20};
  rx_net_model net (.core_clk(core_clk), .rst_n(rst_n), .go(go), .q(q), .bytes(bytes),
    .frameStart(frameStart), .frameDone(frameDone), .flags(flags), .frameBytes(frameBytes));
  receive_filter_status_control uut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frameDone(frameDone),
    .frameStart(frameStart), .tableMatch(flags[5]), .destGroup(flags[4]), .destAllOnes(flags[3]),
    .fcsBad(flags[2]), .alignBad(flags[1]), .collided(flags[0]), .frameBytes(frameBytes),
    .remainingWords(remW), .endThresholdWords(thrW), .carrierPin(carrierPin), .softReset(softReset),
    .frameAccept(frameAccept), .descWrite(descWrite), .descStatusWord(descStatusWord),
    .loopMode(loopMode), .xcvrLoopEnable(xcvrLoopEnable));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
  endtask : rd
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    logic acc, runt, good;
    logic [6:0] h;
    logic [5:0] f;
    int k;
    {rst_n, avs_read, avs_write, go, carrierPin, softReset, avs_address, avs_writedata} = '0;
    {q, bytes, remW, thrW, mreg} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(RFC_OFFSET);
    cmp(rdat, {16'h0000, RFC_RESET});
    rd(CFG2_OFFSET);
    cmp(rdat, {16'h0000, CFG2_RESET});
    rd(4'h0);
    cmp(rdat, UNMAPPED_READ);
    wr(CFG2_OFFSET, 16'h0040);
    for (int i = 0; i < 11; i++)
    begin
      h = hs[i];
      f = qs[i];
      carrierPin <= (i == 2);
      wr(RFC_OFFSET, {h, 9'h1FF});
      @(posedge core_clk);
      cmp({30'h0, loopMode}, {30'h0, h[1:0]});
      cmp({31'h0, xcvrLoopEnable}, {31'h0, h[1:0] == 2'h3});
      mreg[15:9] = h;
      runt = (i == 5);
      acc = (f[5] | h[5] & runt | h[4] & f[3] | h[3] & !f[4] | h[2] & f[4]) & (h[6] | !(f[2] | f[0]));
      good = !(f[2] | f[1] | f[0] | runt);
      go <= 1'b1;
      q <= f;
      bytes <= runt ? MIN_FRAME_BYTES - 16'h0001 : 16'h0064;
      remW <= (i == 9) ? 16'h0005 : 16'h0032;
      thrW <= 16'h0005;
      @(posedge core_clk);
      go <= 1'b0;
      for (k = 0; k < 8 && frameDone !== 1'b1; k++) @(posedge core_clk);
      cmp({31'h0, frameDone}, 32'h1);
      @(posedge core_clk);
      mreg[8:0] = mreg[8:0] & ~STATUS_CLEAR_MASK[8:0];
      if (acc)
        mreg[8:0] = {f[4], f[3], i == 9, mreg[5] | (i == 2), mreg[4] | f[0], f[2] & !f[1], f[2] & f[1],
          h[1:0] != 2'h0 && good, good};
      cmp({31'h0, frameAccept}, {31'h0, acc});
      cmp({31'h0, descWrite}, {31'h0, acc});
      if (acc)
        cmp({16'h0, descStatusWord}, {16'h0, mreg});
      rd(RFC_OFFSET);
      cmp(rdat, {16'h0, mreg});
    end
    wr(CFG2_OFFSET, 16'h0000);
    wr(RFC_OFFSET, 16'h0600);
    @(posedge core_clk);
    cmp({30'h0, loopMode}, 32'h3);
    cmp({31'h0, xcvrLoopEnable}, 32'h0);
    mreg[15:9] = 7'h03;
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    rd(RFC_OFFSET);
    cmp(rdat, {16'h0, mreg});
    wrap_up();
  end
endmodule : tb
`default_nettype wire
